// [cid_regs.v]
/*
  vendor charger detection, headset key and id resistor conversion registers
  reached through ulpi immediate register read and write.
  assumes the ulpi protocol engine hands over decoded accesses on i_mclk:
  one-cycle write strobe with address and data, read strobe with address,
  read data returned from flip-flops the cycle after.
  comparator, line state and id code come from analog/other domains.
*/
// Notes on behaviour
// - comparator output reads 0 unless sink current enable bit 1 is set.
// - bit 0 enables voltage source, bit 2 contact source; bits 0-3 reset 0.
// - host port bit 3 swaps all source, sink, comparator data line connections.
// - detect flag bit 4 is 1 only with comparator high and line state 00.
// - headset mode on only while key bits 3:0 equal 1010; upper bits zero.
// - id register readable at three addresses: write, set, clear.
// - result codes 000 0ohm to 101 floating, 111 error.
// - write or set start bit launches measurement; auto clears at completion.
// - measurement lasts 282 us, then done flag bit 3 rises.
// - reading result through this register clears done flag.
// - reading through carkit status does not clear done flag.
// - enabled done assertion raises alternate interrupt in receive command.
// - effective enable is or of this bit and carkit enable bit.
// - vendor range 30h-3fh reachable by immediate read and write.
// - carkit latch records event when enabled and done rises.
`timescale 1ns/1ps
`default_nettype none
`include "cid_defines.vh"

module cid_regs #(
  parameter CONV_CYCLES = `CID_CONV_CYCLES
) (
  input  wire       i_mclk,
  input  wire       i_rst,
  input  wire       i_reg_wr,
  input  wire       i_reg_rd,
  input  wire [5:0] i_reg_addr,
  input  wire [7:0] i_reg_wdata,
  output reg  [7:0] o_reg_rdata,
  output reg        o_reg_hit,
  input  wire       i_carkit_rid_ien,
  input  wire       i_carkit_status_rd,
  input  wire       i_data_detect_comparator,
  input  wire [1:0] i_line_state,
  input  wire [2:0] i_id_code,
  output wire       o_dp_data_voltage_source,
  output wire       o_dm_data_voltage_source,
  output wire       o_dp_data_sink_current,
  output wire       o_dm_data_sink_current,
  output wire       o_dp_contact_current_source,
  output wire       o_dm_contact_current_source,
  output wire       o_comparator_on_dm,
  output wire       o_headset_mode,
  output wire [2:0] o_id_resistor_result,
  output wire       o_id_conversion_done,
  output reg        o_alt_int,
  output reg        o_carkit_rid_latch_set
);

  // ************************************************************
  // state
  // ************************************************************
  reg  [3:0] chg_reg;
  reg  [3:0] hset_reg;
  reg        start_reg;
  reg        rsvd_reg;
  reg        ien_reg;
  reg        done_reg;
  reg  [2:0] result_reg;
  reg        cmp_s1_reg;
  reg        cmp_s2_reg;
  reg  [1:0] ls_s1_reg;
  reg  [1:0] ls_s2_reg;
  reg  [2:0] id_s1_reg;
  reg  [2:0] id_s2_reg;
  reg  [2:0] id_s3_reg;
  reg  [2:0] id_hold_reg;
  reg        done_reg_pending;
  reg  [7:0] wr_val;
  reg  [7:0] rid_next;
  wire       conv_busy;
  wire       conv_done;
  wire [2:0] conv_result;
  wire       data_detect_flag;
  wire       irq_enable;
  wire       rid_rd;
  wire       start_launch;

  function is_rid_addr;
    input [5:0] a;
    begin
      is_rid_addr = (a == `CID_ADDR_RID_WR) || (a == `CID_ADDR_RID_SET) || (a == `CID_ADDR_RID_CLR);
    end
  endfunction

  // ************************************************************
  // input synchronisers
  // ************************************************************
  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      cmp_s1_reg <= 1'b0;
      cmp_s2_reg <= 1'b0;
      ls_s1_reg  <= 2'h0;
      ls_s2_reg  <= 2'h0;
      id_s1_reg  <= 3'h0;
      id_s2_reg  <= 3'h0;
      id_s3_reg  <= 3'h0;
      id_hold_reg <= 3'h0;
    end else begin
      cmp_s1_reg <= i_data_detect_comparator;
      cmp_s2_reg <= cmp_s1_reg;
      ls_s1_reg  <= i_line_state;
      ls_s2_reg  <= ls_s1_reg;
      id_s1_reg  <= i_id_code;
      id_s2_reg  <= id_s1_reg;
      id_s3_reg  <= id_s2_reg;
      // multi-bit code taken only once two samples agree
      if (id_s2_reg == id_s3_reg) begin
        id_hold_reg <= id_s3_reg;
      end
    end
  end

  // ************************************************************
  // charger detect outputs
  // ************************************************************
  // source enables
  assign o_dp_data_voltage_source    = chg_reg[`CID_CHG_SRC_BIT]  & ~chg_reg[`CID_CHG_HOST_BIT];
  assign o_dm_data_voltage_source    = chg_reg[`CID_CHG_SRC_BIT]  &  chg_reg[`CID_CHG_HOST_BIT];
  assign o_dp_data_sink_current      = chg_reg[`CID_CHG_SINK_BIT] & ~chg_reg[`CID_CHG_HOST_BIT];
  assign o_dm_data_sink_current      = chg_reg[`CID_CHG_SINK_BIT] &  chg_reg[`CID_CHG_HOST_BIT];
  assign o_dp_contact_current_source = chg_reg[`CID_CHG_CONT_BIT] & ~chg_reg[`CID_CHG_HOST_BIT];
  assign o_dm_contact_current_source = chg_reg[`CID_CHG_CONT_BIT] &  chg_reg[`CID_CHG_HOST_BIT];
  assign o_comparator_on_dm          = chg_reg[`CID_CHG_HOST_BIT];
  assign data_detect_flag = chg_reg[`CID_CHG_SINK_BIT] & cmp_s2_reg & (ls_s2_reg == 2'h0);
  assign o_headset_mode = (hset_reg == `CID_HSET_KEY);

  // ************************************************************
  // id conversion
  // ************************************************************
  assign rid_rd               = i_reg_rd && is_rid_addr(i_reg_addr);
  assign irq_enable           = ien_reg | i_carkit_rid_ien;
  assign o_id_resistor_result = result_reg;
  assign o_id_conversion_done = done_reg;
  assign start_launch         = start_reg && !conv_busy && !done_reg_pending;

  cid_rid_conv #(
    .CONV_CYCLES (CONV_CYCLES)
  ) u_conv (
    .i_mclk    (i_mclk),
    .i_rst     (i_rst),
    .i_start   (start_launch),
    .i_id_code (id_hold_reg),
    .o_busy    (conv_busy),
    .o_done    (conv_done),
    .o_result  (conv_result)
  );

  // ************************************************************
  // register writes, combinational next value of id register
  // ************************************************************
  always @* begin
    wr_val   = {1'b0, ien_reg, rsvd_reg, start_reg, 1'b0, 3'h0};
    rid_next = wr_val;
    if (i_reg_wr && i_reg_addr == `CID_ADDR_RID_WR) begin
      rid_next = i_reg_wdata;
    end else if (i_reg_wr && i_reg_addr == `CID_ADDR_RID_SET) begin
      rid_next = wr_val | i_reg_wdata;
    end else if (i_reg_wr && i_reg_addr == `CID_ADDR_RID_CLR) begin
      rid_next = wr_val & ~i_reg_wdata;
    end
  end

  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      chg_reg          <= `CID_CHG_RESET;
      hset_reg         <= `CID_HSET_RESET;
      start_reg        <= 1'b0;
      rsvd_reg         <= 1'b0;
      ien_reg          <= 1'b0;
      done_reg         <= 1'b0;
      result_reg       <= `CID_RID_RESET;
      done_reg_pending <= 1'b0;
      o_alt_int        <= 1'b0;
      o_carkit_rid_latch_set <= 1'b0;
    end else begin
      if (i_reg_wr && i_reg_addr == `CID_ADDR_CHG) begin
        chg_reg <= i_reg_wdata[3:0];
      end
      if (i_reg_wr && i_reg_addr == `CID_ADDR_HSET) begin
        hset_reg <= i_reg_wdata[3:0];
      end
      rsvd_reg <= rid_next[`CID_RID_RSVD_BIT];
      ien_reg  <= rid_next[`CID_RID_IEN_BIT];
      // auto clear on completion beats write
      if (conv_done) begin
        start_reg <= 1'b0;
      end else begin
        start_reg <= rid_next[`CID_RID_START_BIT];
      end
      done_reg_pending <= conv_busy;
      if (conv_done) begin
        result_reg <= conv_result;
      end
      // done set wins over read clear
      if (conv_done) begin
        done_reg <= 1'b1;
      end else if (rid_rd) begin
        done_reg <= 1'b0;
      end
      o_alt_int              <= conv_done && !done_reg && irq_enable;
      o_carkit_rid_latch_set <= conv_done && !done_reg && irq_enable;
    end
  end

  // ************************************************************
  // register read
  // ************************************************************
  // immediate reads of vendor range
  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_reg_rdata <= 8'h00;
      o_reg_hit   <= 1'b0;
    end else if (i_reg_rd) begin
      o_reg_hit <= (i_reg_addr >= `CID_ADDR_VEND_LO) && (i_reg_addr <= `CID_ADDR_VEND_HI);
      if (i_reg_addr == `CID_ADDR_CHG) begin
        o_reg_rdata <= {3'h0, data_detect_flag, chg_reg};
      end else if (i_reg_addr == `CID_ADDR_HSET) begin
        o_reg_rdata <= {4'h0, hset_reg};
      end else if (is_rid_addr(i_reg_addr)) begin
        o_reg_rdata <= {1'b0, ien_reg, rsvd_reg, start_reg, done_reg, result_reg};
      end else begin
        o_reg_rdata <= 8'h00;
      end
    end
  end

endmodule // cid_regs
`default_nettype wire

// [cid_defines.vh]
/*
  register offsets, field positions, reset values and timing counts for the
  charger and id detection register bank.
  assumes inclusion by bare name from the design files.
*/
`ifndef CID_DEFINES_VH
`define CID_DEFINES_VH

// ************************************************************
// register offsets (6-bit ulpi register address)
// ************************************************************
`define CID_ADDR_VEND_LO   6'h30
`define CID_ADDR_VEND_HI   6'h3f
`define CID_ADDR_CHG       6'h32
`define CID_ADDR_HSET      6'h33
`define CID_ADDR_RID_WR    6'h36
`define CID_ADDR_RID_SET   6'h37
`define CID_ADDR_RID_CLR   6'h38

// ************************************************************
// field positions
// ************************************************************
`define CID_CHG_SRC_BIT    0
`define CID_CHG_SINK_BIT   1
`define CID_CHG_CONT_BIT   2
`define CID_CHG_HOST_BIT   3
`define CID_CHG_DET_BIT    4
`define CID_RID_DONE_BIT   3
`define CID_RID_START_BIT  4
`define CID_RID_RSVD_BIT   5
`define CID_RID_IEN_BIT    6

// ************************************************************
// reset values and key
// ************************************************************
`define CID_CHG_RESET      4'h0
`define CID_HSET_RESET     4'h0
`define CID_HSET_KEY       4'ha
`define CID_RID_RESET      3'h0
`define CID_RID_ERROR      3'h7

// ************************************************************
// timing
// ************************************************************
`define CID_CLK_MHZ        250
`define CID_CONV_TIME_US   282
`define CID_CONV_CYCLES    (`CID_CONV_TIME_US * `CID_CLK_MHZ)

`endif

// [cid_rid_conv.v]
/*
  id resistor conversion timer: runs a fixed-length measurement, then
  delivers the sampled result code with a one-cycle done pulse.
  assumes i_id_code is already synchronised to i_mclk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "cid_defines.vh"

module cid_rid_conv #(
  parameter CONV_CYCLES = `CID_CONV_CYCLES
) (
  input  wire       i_mclk,
  input  wire       i_rst,
  input  wire       i_start,
  input  wire [2:0] i_id_code,
  output reg        o_busy,
  output reg        o_done,
  output reg  [2:0] o_result
);

  reg [19:0] cnt_reg;

  // ************************************************************
  // measurement counter
  // ************************************************************
  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      cnt_reg  <= 20'h00000;
      o_busy   <= 1'b0;
      o_done   <= 1'b0;
      o_result <= 3'h0;
    end else begin
      o_done <= 1'b0;
      if (!o_busy && i_start) begin
        o_busy  <= 1'b1;
        cnt_reg <= CONV_CYCLES[19:0] - 20'h00001;
      end else if (o_busy) begin
        if (cnt_reg == 20'h00000) begin
          o_busy   <= 1'b0;
          o_done   <= 1'b1;
          // code 110 unused, mapped to error
          o_result <= (i_id_code == 3'h6) ? `CID_RID_ERROR : i_id_code;
        end else begin
          cnt_reg <= cnt_reg - 20'h00001;
        end
      end
    end
  end

endmodule // cid_rid_conv
`default_nettype wire

// [cid_regs_chk.sv]
/* port assertions for cid_regs.
   assumes one clock i_mclk and async active high i_rst. */
`timescale 1ns/1ps
`default_nettype none
module cid_regs_chk #(
  parameter CONV_CYCLES = 70500
) (
  input wire logic       i_mclk,
  input wire logic       i_rst,
  input wire logic       i_reg_rd,
  input wire logic [5:0] i_reg_addr,
  input wire logic [7:0] o_reg_rdata,
  input wire logic       o_reg_hit,
  input wire logic       i_carkit_rid_ien,
  input wire logic       i_carkit_status_rd,
  input wire logic       o_dp_data_voltage_source,
  input wire logic       o_dp_data_sink_current,
  input wire logic       o_dm_data_sink_current,
  input wire logic       o_dp_contact_current_source,
  input wire logic       o_comparator_on_dm,
  input wire logic       o_headset_mode,
  input wire logic       o_id_conversion_done,
  input wire logic       o_alt_int,
  input wire logic       o_carkit_rid_latch_set
);
  // ************************************************************
  // assertions
  // ************************************************************
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  wire logic rid_rd = i_reg_rd && i_reg_addr >= 6'h36 && i_reg_addr <= 6'h38;
  sink_gates_det_a: assert property (i_reg_rd && i_reg_addr == 6'h32 && !o_dp_data_sink_current
    && !o_dm_data_sink_current |=> !o_reg_rdata[4]) else $error("detect flag without sink");
  host_swap_a: assert property (o_comparator_on_dm |-> !(o_dp_data_voltage_source ||
    o_dp_data_sink_current || o_dp_contact_current_source)) else $error("source left on dp");
  chg_upper_zero_a: assert property (i_reg_rd && i_reg_addr == 6'h32 |=> o_reg_rdata[7:5] == 3'h0)
    else $error("charger upper bits set");
  hset_key_a: assert property (i_reg_rd && i_reg_addr == 6'h33 |=> o_reg_rdata[7:4] == 4'h0 &&
    (o_reg_rdata[3:0] == 4'ha) == $past(o_headset_mode)) else $error("headset key mismatch");
  rid_top_zero_a: assert property (rid_rd |=> !o_reg_rdata[7]) else $error("rid bit 7 set");
  done_read_clr_a: assert property (rid_rd && o_id_conversion_done |=> o_reg_rdata[3]
    && !o_id_conversion_done) else $error("done not cleared by read");
  carkit_keep_a: assert property (i_carkit_status_rd && !i_reg_rd && o_id_conversion_done
    |=> o_id_conversion_done) else $error("carkit read cleared done");
  irq_enable_a: assert property ($rose(o_id_conversion_done) && i_carkit_rid_ien &&
    $past(i_carkit_rid_ien) |-> o_alt_int) else $error("missing alt interrupt");
  irq_cause_a: assert property (o_alt_int |-> $rose(o_id_conversion_done)) else $error("stray alt int");
  latch_pulse_a: assert property (o_carkit_rid_latch_set == o_alt_int) else $error("latch pulse differs");
  hit_range_a: assert property (i_reg_rd |=> o_reg_hit == ($past(i_reg_addr[5:4]) == 2'h3))
    else $error("hit flag wrong");
endmodule // cid_regs_chk
bind cid_regs cid_regs_chk #(.CONV_CYCLES(CONV_CYCLES)) u_chk (
  .i_mclk(i_mclk), .i_rst(i_rst), .i_reg_rd(i_reg_rd),
  .i_reg_addr(i_reg_addr), .o_reg_rdata(o_reg_rdata), .o_reg_hit(o_reg_hit), .i_carkit_rid_ien(i_carkit_rid_ien),
  .i_carkit_status_rd(i_carkit_status_rd), .o_dp_data_voltage_source(o_dp_data_voltage_source),
  .o_dp_data_sink_current(o_dp_data_sink_current), .o_dm_data_sink_current(o_dm_data_sink_current),
  .o_dp_contact_current_source(o_dp_contact_current_source), .o_comparator_on_dm(o_comparator_on_dm),
  .o_headset_mode(o_headset_mode), .o_id_conversion_done(o_id_conversion_done), .o_alt_int(o_alt_int),
  .o_carkit_rid_latch_set(o_carkit_rid_latch_set));
`default_nettype wire

// [cid_link_model.sv]
/* link controller model: immediate register writes and reads.
   assumes the tb calls its tasks; strobes change at falling edges. */
`timescale 1ns/1ps
`default_nettype none
module cid_link_model (
  input  wire logic       i_mclk,
  input  wire logic [7:0] i_rdata,
  output var  logic       o_wr,
  output var  logic       o_rd,
  output var  logic [5:0] o_addr,
  output var  logic [7:0] o_wdata
);
  initial begin
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_addr = 6'h00;
    o_wdata = 8'h00;
  end
  // ************************************************************
  // caller keeps data legal
  // ************************************************************
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(negedge i_mclk);
    o_wr = 1'b1;
    o_addr = a;
    o_wdata = d;
    @(negedge i_mclk);
    o_wr = 1'b0;
    o_addr = ~a;
    o_wdata = ~d;
  endtask
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    @(negedge i_mclk);
    o_rd = 1'b1;
    o_addr = a;
    @(negedge i_mclk);
    o_rd = 1'b0;
    o_addr = ~a;
    d = i_rdata;
  endtask
endmodule // cid_link_model
`default_nettype wire

// [cid_regs_tb_top.sv]
/* self-checking bench for cid_regs.
   assumes cid_link_model and cid_regs_chk compiled before. */
`timescale 1ns/1ps
`default_nettype none
module cid_regs_tb_top;
  localparam int CONV = 20;
  logic i_mclk = 1'b0, i_rst = 1'b1, i_reg_wr, i_reg_rd, i_carkit_rid_ien = 1'b0, i_carkit_status_rd = 1'b0;
  logic i_data_detect_comparator = 1'b0, o_reg_hit, o_comparator_on_dm, o_headset_mode;
  logic o_dp_data_voltage_source, o_dm_data_voltage_source, o_dp_data_sink_current, o_dm_data_sink_current;
  logic o_dp_contact_current_source, o_dm_contact_current_source, o_id_conversion_done, o_alt_int;
  logic o_carkit_rid_latch_set, irq;
  logic [1:0] i_line_state = 2'h0;
  logic [2:0] i_id_code = 3'h0, o_id_resistor_result;
  logic [5:0] i_reg_addr;
  logic [7:0] i_reg_wdata, o_reg_rdata, d, v;
  logic [31:0] seed = 32'h2131;
  int error_cnt = 0, samples_checked = 0, n;
  always #2 i_mclk = ~i_mclk;
  cid_regs #(.CONV_CYCLES(CONV)) dut (.i_mclk(i_mclk), .i_rst(i_rst), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
    .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata), .o_reg_hit(o_reg_hit),
    .i_carkit_rid_ien(i_carkit_rid_ien), .i_carkit_status_rd(i_carkit_status_rd),
    .i_data_detect_comparator(i_data_detect_comparator), .i_line_state(i_line_state), .i_id_code(i_id_code),
    .o_dp_data_voltage_source(o_dp_data_voltage_source), .o_dm_data_voltage_source(o_dm_data_voltage_source),
    .o_dp_data_sink_current(o_dp_data_sink_current), .o_dm_data_sink_current(o_dm_data_sink_current),
    .o_dp_contact_current_source(o_dp_contact_current_source),
    .o_dm_contact_current_source(o_dm_contact_current_source), .o_comparator_on_dm(o_comparator_on_dm),
    .o_headset_mode(o_headset_mode), .o_id_resistor_result(o_id_resistor_result),
    .o_id_conversion_done(o_id_conversion_done), .o_alt_int(o_alt_int),
    .o_carkit_rid_latch_set(o_carkit_rid_latch_set));
  cid_link_model u_link (.i_mclk(i_mclk), .i_rdata(o_reg_rdata), .o_wr(i_reg_wr), .o_rd(i_reg_rd),
    .o_addr(i_reg_addr), .o_wdata(i_reg_wdata));
  // ************************************************************
  // helpers
  // ************************************************************
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [7:0] route(input logic [3:0] c);
    return {1'b0, c[3] & c[0], !c[3] & c[0], c[3] & c[1], !c[3] & c[1], c[3] & c[2], !c[3] & c[2], c[3]};
  endfunction
  function automatic logic [2:0] code(input logic [2:0] c);
    return (c == 3'h6) ? 3'h7 : c;
  endfunction
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic chk_route(input logic [3:0] c);
    logic [7:0] seen;
    seen = {1'b0, o_dm_data_voltage_source, o_dp_data_voltage_source, o_dm_data_sink_current, o_dp_data_sink_current,
      o_dm_contact_current_source, o_dp_contact_current_source, o_comparator_on_dm};
    check(seen, route(c));
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #100000;
    error_cnt++;
    close_out();
  end
  // ************************************************************
  // scenarios
  // ************************************************************
  initial begin
    repeat (20) @(negedge i_mclk);
    i_rst = 1'b0;
    for (int k = 0; k < 5; k++) begin
      u_link.rd(6'h32 + ((k < 2) ? k : k + 2), d);
      check(d, 8'h00);
    end
    for (int i = 0; i < 24; i++) begin
      v = rnd();
      if (i < 16)
        v[3:0] = i;
      i_data_detect_comparator = v[4];
      i_line_state = v[6:5] & {2{v[7]}};
      u_link.wr(6'h32, v);
      repeat (3) @(negedge i_mclk);
      u_link.rd(6'h32, d);
      check(d, {3'h0, v[1] & v[4] & (i_line_state == 2'h0), v[3:0]});
      chk_route(v[3:0]);
    end
    for (int k = 0; k < 3; k++) begin
      v = (k == 0) ? 8'hfa : (k == 1) ? 8'h0b : 8'h5a;
      u_link.wr(6'h33, v);
      u_link.rd(6'h33, d);
      check(d, {4'h0, v[3:0]});
      check({7'h0, o_headset_mode}, {7'h0, v[3:0] == 4'ha});
    end
    for (int i = 0; i < 8; i++) begin
      i_id_code = i;
      i_carkit_rid_ien = i[0];
      if (i[0]) begin
        u_link.wr(6'h38, 8'h40);
        u_link.wr(6'h37, 8'h10);
      end else
        u_link.wr(6'h36, 8'h50);
      n = 0;
      irq = 1'b0;
      while (o_id_conversion_done !== 1'b1 && n < CONV + 20) begin
        @(negedge i_mclk);
        n++;
        irq |= o_alt_int;
      end
      check({7'h0, n >= CONV && n <= CONV + 5}, 8'h01);
      check({7'h0, irq}, 8'h01);
      check({5'h0, o_id_resistor_result}, {5'h0, code(i)});
      i_carkit_status_rd = 1'b1;
      @(negedge i_mclk);
      i_carkit_status_rd = 1'b0;
      check({7'h0, o_id_conversion_done}, 8'h01);
      u_link.rd(6'h36 + i % 3, d);
      check(d, {1'b0, !i[0], 3'h1, code(i)});
      u_link.rd(6'h38, d);
      check(d, {1'b0, !i[0], 3'h0, code(i)});
    end
    u_link.rd(6'h3e, d);
    check({d[6:0], o_reg_hit}, 8'h01);
    u_link.rd(6'h10, d);
    check({d[6:0], o_reg_hit}, 8'h00);
    u_link.wr(6'h32, 8'h08);
    chk_route(4'h8);
    i_rst = 1'b1;
    repeat (2) @(negedge i_mclk);
    i_rst = 1'b0;
    chk_route(4'h0);
    u_link.rd(6'h33, d);
    check(d, 8'h00);
    check({7'h0, o_headset_mode}, 8'h00);
    u_link.rd(6'h36, d);
    check(d, 8'h00);
    close_out();
  end
endmodule // cid_regs_tb_top
`default_nettype wire
